// >>> pbcr_pkg.sv
/*
  Constants, types and helper functions shared by the per-port PHY basic
  control register bank. Assumes a single 200 MHz management clock domain.
*/
package pbcr_pkg;

  // ==========================================================================
  // widths and port map
  // ==========================================================================
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned ADDR_W    = 5;
  localparam int unsigned SPI_ADDR_W = 8;
  localparam int unsigned NUM_PORTS = 3;

  localparam logic [4:0] PHYAD_PORT1 = 5'h01;
  localparam logic [4:0] PHYAD_PORT3 = 5'h03;

  // host port window: base + port * stride + register address
  localparam logic [7:0] SPI_PHY_BASE    = 8'h00;
  localparam logic [7:0] SPI_PORT_STRIDE = 8'h20;

  // ==========================================================================
  // register addresses
  // ==========================================================================
  localparam logic [4:0] REGAD_BASIC_CONTROL = 5'h00;
  localparam logic [4:0] REGAD_LAST_STD      = 5'h05;
  localparam logic [4:0] REGAD_EXT_A         = 5'h1D;
  localparam logic [4:0] REGAD_EXT_B         = 5'h1F;

  // ==========================================================================
  // basic control field positions
  // ==========================================================================
  localparam int unsigned BIT_SOFT_RESET      = 15;
  localparam int unsigned BIT_MAC_LOOPBACK    = 14;
  localparam int unsigned BIT_SPEED_100       = 13;
  localparam int unsigned BIT_AUTONEG_ENABLE  = 12;
  localparam int unsigned BIT_POWER_DOWN      = 11;
  localparam int unsigned BIT_LINE_ISOLATE    = 10;
  localparam int unsigned BIT_AUTONEG_RESTART = 9;
  localparam int unsigned BIT_DUPLEX_FULL     = 8;
  localparam int unsigned BIT_XOVER_ALGO      = 5;
  localparam int unsigned BIT_FORCED_WIRING   = 4;
  localparam int unsigned BIT_AUTO_XOVER_DIS  = 3;
  localparam int unsigned BIT_FEF_DISABLE     = 2;
  localparam int unsigned BIT_TX_DISABLE      = 1;
  localparam int unsigned BIT_INDICATOR_DIS   = 0;

  // value after reset and the bits that hold state (15, 9, 7, 6 store nothing)
  localparam logic [15:0] CTRL_RESET_VAL = 16'h3120;
  localparam logic [15:0] CTRL_STORE_MASK = 16'h7D3F;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS     = 5;
  localparam int unsigned SOFT_RST_TIME_NS  = 100;
  localparam int unsigned SOFT_RST_CYCLES   =
    (SOFT_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SOFT_RST_CNT_W    = 5;
  localparam logic [4:0]  SOFT_RST_LAST     = 5'(SOFT_RST_CYCLES - 1);

  typedef enum logic [0:0] {
    PBCR_PS_RUN,
    PBCR_PS_SOFT_RESET
  } pbcr_port_state_e;

  // ==========================================================================
  // decode helpers
  // ==========================================================================
  function automatic logic pbcr_regad_supported(input logic [4:0] regad);
    return (regad <= REGAD_LAST_STD) || (regad == REGAD_EXT_A) ||
           (regad == REGAD_EXT_B);
  endfunction : pbcr_regad_supported

  function automatic logic pbcr_phyad_hit(input logic [4:0] phyad);
    return (phyad >= PHYAD_PORT1) && (phyad <= PHYAD_PORT3);
  endfunction : pbcr_phyad_hit

  function automatic logic [1:0] pbcr_phyad_index(input logic [4:0] phyad);
    logic [4:0] diff;
    diff = phyad - PHYAD_PORT1;
    return diff[1:0];
  endfunction : pbcr_phyad_index

endpackage : pbcr_pkg

// >>> pbcr_port_ctrl.sv
/*
  One port's basic control register with self-clearing soft reset and
  auto-negotiation restart. Assumes one-cycle write strobes from the bank.
*/
module pbcr_port_ctrl
  import pbcr_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        srst_in,
  input  wire logic        ce_in,
  input  wire logic        wr_en_in,
  input  wire logic [15:0] wdata_in,
  output logic      [15:0] ctrl_out,
  output logic             soft_reset_out,
  output logic             autoneg_restart_out
);

  // ==========================================================================
  // state
  // ==========================================================================
  pbcr_port_state_e    state_q;
  pbcr_port_state_e    state_d;
  logic [15:0]         ctrl_q;
  logic [15:0]         ctrl_d;
  logic [4:0]          cnt_q;
  logic [4:0]          cnt_d;
  logic                restart_d;
  logic                soft_d;

  wire logic wr_ok   = wr_en_in && (state_q == PBCR_PS_RUN);
  wire logic soft_go = wr_ok && wdata_in[BIT_SOFT_RESET];

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    state_d   = state_q;
    ctrl_d    = ctrl_q;
    cnt_d     = cnt_q;
    restart_d = 1'b0;
    unique case (state_q)
      PBCR_PS_RUN: begin
        if (soft_go) begin
          // soft reset wins over any other bit of the same write
          state_d = PBCR_PS_SOFT_RESET;
          ctrl_d  = CTRL_RESET_VAL;
          cnt_d   = SOFT_RST_LAST;
        end else if (wr_ok) begin
          ctrl_d    = wdata_in & CTRL_STORE_MASK;
          restart_d = wdata_in[BIT_AUTONEG_RESTART];
        end
      end
      PBCR_PS_SOFT_RESET: begin
        // writes are dropped until the port comes out of reset
        if (cnt_q == 5'h00) begin
          state_d = PBCR_PS_RUN;
        end else begin
          cnt_d = cnt_q - 5'h01;
        end
      end
    endcase
    soft_d = (state_d == PBCR_PS_SOFT_RESET);
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state_q             <= PBCR_PS_RUN;
      ctrl_q              <= CTRL_RESET_VAL;
      cnt_q               <= 5'h00;
      soft_reset_out      <= 1'b0;
      autoneg_restart_out <= 1'b0;
    end else if (ce_in) begin
      state_q             <= state_d;
      ctrl_q              <= ctrl_d;
      cnt_q               <= cnt_d;
      soft_reset_out      <= soft_d;
      autoneg_restart_out <= restart_d;
    end
  end

  // bit 15 reads one only while the reset is running
  assign ctrl_out = ctrl_q | {soft_reset_out, 15'h0000};

endmodule : pbcr_port_ctrl

// >>> pbcr_bank.sv
/*
  Basic control register bank for three copper ports, reached by a
  management-frame request port (PHY and register address) and a host
  port with its own flat byte addressing. Both request ports are logic on
  the same clock and keep req high until ack; status, identifier and
  advertisement registers live elsewhere and read as zero here.
*/
// Summary of operation
// - PHY addresses 1, 2, 3 select ports
// - register addresses 0-5, 1D, 1F supported
// - host port reaches same registers, other mapping
// - bit 15 soft-resets port, then self-clears
// - bit 14 loops traffic at MAC/PHY
// - bit 13 forces 100 or 10 Mbps
// - bit 12 enables auto-negotiation, reset one
// - bit 11 powers the PHY down
// - bit 10 isolates PHY from transmit pair
// - bit 9 restarts auto-negotiation
// - bit 8 forces full or half duplex
// - bit 5 selects crossover algorithm variant
// - bit 4 forces straight or crossed wiring
// - bit 3 disables automatic crossover detection
// - bit 2 disables far-end-fault detection
// - bit 1 disables the transmitter
// - bit 0 disables LED indicators
module pbcr_bank
  import pbcr_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        srst_in,
  input  wire logic        ce_in,
  input  wire logic        mgmt_req_in,
  input  wire logic        mgmt_wr_in,
  input  wire logic [4:0]  mgmt_phy_addr_in,
  input  wire logic [4:0]  mgmt_reg_addr_in,
  input  wire logic [15:0] mgmt_wdata_in,
  output logic             mgmt_ack_out,
  output logic             mgmt_err_out,
  output logic      [15:0] mgmt_rdata_out,
  input  wire logic        spi_req_in,
  input  wire logic        spi_wr_in,
  input  wire logic [7:0]  spi_addr_in,
  input  wire logic [15:0] spi_wdata_in,
  output logic             spi_ack_out,
  output logic             spi_err_out,
  output logic      [15:0] spi_rdata_out,
  output logic      [2:0]  phy_soft_reset_out,
  output logic      [2:0]  mac_loopback_out,
  output logic      [2:0]  speed_100_out,
  output logic      [2:0]  autoneg_enable_out,
  output logic      [2:0]  power_down_out,
  output logic      [2:0]  line_isolate_out,
  output logic      [2:0]  autoneg_restart_out,
  output logic      [2:0]  duplex_full_out,
  output logic      [2:0]  crossover_algorithm_select_out,
  output logic      [2:0]  forced_wiring_select_out,
  output logic      [2:0]  auto_crossover_disable_out,
  output logic      [2:0]  far_end_fault_disable_out,
  output logic      [2:0]  tx_disable_out,
  output logic      [2:0]  indicator_disable_out
);

  // ==========================================================================
  // management request decode
  // ==========================================================================
  logic [15:0] ctrl_vec [NUM_PORTS];
  logic [2:0]  port_wr_en;
  logic [15:0] port_wdata;
  logic [2:0]  soft_busy;

  wire logic       mgmt_take     = ce_in && mgmt_req_in && !mgmt_ack_out;
  wire logic       mgmt_port_hit = pbcr_phyad_hit(mgmt_phy_addr_in);
  wire logic [1:0] mgmt_idx      = pbcr_phyad_index(mgmt_phy_addr_in);
  wire logic       mgmt_reg_ok   = pbcr_regad_supported(mgmt_reg_addr_in);
  wire logic       mgmt_valid    = mgmt_port_hit && mgmt_reg_ok;
  wire logic       mgmt_is_ctrl  = mgmt_valid &&
                                   (mgmt_reg_addr_in == REGAD_BASIC_CONTROL);

  // ==========================================================================
  // host port decode
  // ==========================================================================
  // the host window holds three 32-entry blocks, one per port
  wire logic [7:0] spi_off      = spi_addr_in - SPI_PHY_BASE;
  wire logic [7:0] spi_blk      = spi_off / SPI_PORT_STRIDE;
  wire logic [4:0] spi_regad    = spi_off[4:0];
  wire logic [1:0] spi_idx      = spi_blk[1:0];
  wire logic       spi_port_hit = (spi_addr_in >= SPI_PHY_BASE) &&
                                  (spi_blk < 8'(NUM_PORTS));
  wire logic       spi_valid    = spi_port_hit && pbcr_regad_supported(spi_regad);
  wire logic       spi_is_ctrl  = spi_valid && (spi_regad == REGAD_BASIC_CONTROL);

  // management frames have priority; a held host request is taken later
  wire logic spi_take = ce_in && spi_req_in && !spi_ack_out && !mgmt_take;

  // ==========================================================================
  // write steering
  // ==========================================================================
  wire logic mgmt_wr_ctrl = mgmt_take && mgmt_wr_in && mgmt_is_ctrl;
  wire logic spi_wr_ctrl  = spi_take && spi_wr_in && spi_is_ctrl;

  assign port_wdata = mgmt_wr_ctrl ? mgmt_wdata_in : spi_wdata_in;

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      assign port_wr_en[gp] = (mgmt_wr_ctrl && (mgmt_idx == 2'(gp))) ||
                              (spi_wr_ctrl && (spi_idx == 2'(gp)));

      pbcr_port_ctrl u_ctrl (
        .ref_clk_in          (ref_clk_in),
        .srst_in             (srst_in),
        .ce_in               (ce_in),
        .wr_en_in            (port_wr_en[gp]),
        .wdata_in            (port_wdata),
        .ctrl_out            (ctrl_vec[gp]),
        .soft_reset_out      (soft_busy[gp]),
        .autoneg_restart_out (autoneg_restart_out[gp])
      );

      // controls go straight from the register flops to the PHY
      assign phy_soft_reset_out[gp]             = soft_busy[gp];
      assign mac_loopback_out[gp]               = ctrl_vec[gp][BIT_MAC_LOOPBACK];
      assign speed_100_out[gp]                  = ctrl_vec[gp][BIT_SPEED_100];
      assign autoneg_enable_out[gp]             = ctrl_vec[gp][BIT_AUTONEG_ENABLE];
      assign power_down_out[gp]                 = ctrl_vec[gp][BIT_POWER_DOWN];
      assign line_isolate_out[gp]               = ctrl_vec[gp][BIT_LINE_ISOLATE];
      assign duplex_full_out[gp]                = ctrl_vec[gp][BIT_DUPLEX_FULL];
      assign crossover_algorithm_select_out[gp] = ctrl_vec[gp][BIT_XOVER_ALGO];
      assign forced_wiring_select_out[gp]       = ctrl_vec[gp][BIT_FORCED_WIRING];
      assign auto_crossover_disable_out[gp]     = ctrl_vec[gp][BIT_AUTO_XOVER_DIS];
      assign far_end_fault_disable_out[gp]      = ctrl_vec[gp][BIT_FEF_DISABLE];
      assign tx_disable_out[gp]                 = ctrl_vec[gp][BIT_TX_DISABLE];
      assign indicator_disable_out[gp]          = ctrl_vec[gp][BIT_INDICATOR_DIS];
    end
  endgenerate

  // ==========================================================================
  // read data
  // ==========================================================================
  // the words come in as arguments so that the continuous assignments below
  // follow every register change, not only address changes
  function automatic logic [15:0] pick_ctrl(input logic [1:0]  idx,
                                            input logic        is_ctrl,
                                            input logic [15:0] w0,
                                            input logic [15:0] w1,
                                            input logic [15:0] w2);
    logic [15:0] v;
    v = 16'h0000;
    if (is_ctrl) begin
      unique case (idx)
        2'd0:    v = w0;
        2'd1:    v = w1;
        2'd2:    v = w2;
        default: v = 16'h0000;
      endcase
    end
    return v;
  endfunction : pick_ctrl

  // other supported registers are owned outside and read as zero here
  wire logic [15:0] mgmt_rd_word = pick_ctrl(mgmt_idx, mgmt_is_ctrl,
                                             ctrl_vec[0], ctrl_vec[1], ctrl_vec[2]);
  wire logic [15:0] spi_rd_word  = pick_ctrl(spi_idx, spi_is_ctrl,
                                             ctrl_vec[0], ctrl_vec[1], ctrl_vec[2]);

  // ==========================================================================
  // answers: ack one cycle after the take, one cycle wide
  // ==========================================================================
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      mgmt_ack_out   <= 1'b0;
      mgmt_err_out   <= 1'b0;
      mgmt_rdata_out <= 16'h0000;
    end else if (ce_in) begin
      mgmt_ack_out   <= mgmt_take;
      mgmt_err_out   <= mgmt_take && !mgmt_valid;
      mgmt_rdata_out <= (mgmt_take && !mgmt_wr_in) ? mgmt_rd_word : 16'h0000;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      spi_ack_out   <= 1'b0;
      spi_err_out   <= 1'b0;
      spi_rdata_out <= 16'h0000;
    end else if (ce_in) begin
      spi_ack_out   <= spi_take;
      spi_err_out   <= spi_take && !spi_valid;
      spi_rdata_out <= (spi_take && !spi_wr_in) ? spi_rd_word : 16'h0000;
    end
  end

  // ==========================================================================
  // assertions (port 0 stands for all three)
  // ==========================================================================
  wire logic wr0_ok = port_wr_en[0] && !soft_busy[0] && !port_wdata[BIT_SOFT_RESET];

  property p_phyad_decode;
    @(posedge ref_clk_in) disable iff (srst_in || !ce_in)
    (mgmt_take && !mgmt_port_hit) |=> (mgmt_ack_out && mgmt_err_out);
  endproperty
  a_phyad_decode: assert property (p_phyad_decode)
    else $error("unknown phy address not flagged");

  property p_regad_unsupported;
    @(posedge ref_clk_in) disable iff (srst_in || !ce_in)
    (mgmt_take && mgmt_port_hit && !mgmt_reg_ok) |=>
      (mgmt_err_out && mgmt_rdata_out == 16'h0000);
  endproperty
  a_regad_unsupported: assert property (p_regad_unsupported)
    else $error("unsupported register not refused");

  property p_spi_read_port0;
    @(posedge ref_clk_in) disable iff (srst_in || !ce_in)
    (spi_take && !spi_wr_in && spi_is_ctrl && spi_idx == 2'd0) |=>
      (spi_ack_out && spi_rdata_out == $past(ctrl_vec[0]));
  endproperty
  a_spi_read_port0: assert property (p_spi_read_port0)
    else $error("host read of port 0 control mismatched");

  property p_soft_reset_len;
    @(posedge ref_clk_in) disable iff (srst_in || !ce_in)
    (port_wr_en[0] && !soft_busy[0] && port_wdata[BIT_SOFT_RESET]) |=>
      soft_busy[0] [*8] ##[1:30] !soft_busy[0];
  endproperty
  a_soft_reset_len: assert property (p_soft_reset_len)
    else $error("soft reset length wrong");

  property p_soft_reset_defaults;
    @(posedge ref_clk_in) disable iff (srst_in || !ce_in)
    $fell(soft_busy[0]) |-> (ctrl_vec[0] == CTRL_RESET_VAL);
  endproperty
  a_soft_reset_defaults: assert property (p_soft_reset_defaults)
    else $error("soft reset left non-default control");

  property p_loopback_write;
    @(posedge ref_clk_in) disable iff (srst_in || !ce_in)
    wr0_ok |=> (mac_loopback_out[0] == $past(port_wdata[BIT_MAC_LOOPBACK]));
  endproperty
  a_loopback_write: assert property (p_loopback_write)
    else $error("loopback bit not taken");

  property p_speed_duplex_write;
    @(posedge ref_clk_in) disable iff (srst_in || !ce_in)
    wr0_ok |=> (speed_100_out[0] == $past(port_wdata[BIT_SPEED_100])) &&
               (duplex_full_out[0] == $past(port_wdata[BIT_DUPLEX_FULL]));
  endproperty
  a_speed_duplex_write: assert property (p_speed_duplex_write)
    else $error("forced speed or duplex not taken");

  property p_mode_bits_write;
    @(posedge ref_clk_in) disable iff (srst_in || !ce_in)
    wr0_ok |=> (autoneg_enable_out[0] == $past(port_wdata[BIT_AUTONEG_ENABLE])) &&
               (power_down_out[0] == $past(port_wdata[BIT_POWER_DOWN])) &&
               (line_isolate_out[0] == $past(port_wdata[BIT_LINE_ISOLATE]));
  endproperty
  a_mode_bits_write: assert property (p_mode_bits_write)
    else $error("autoneg, power down or isolate bit not taken");

  property p_crossover_write;
    @(posedge ref_clk_in) disable iff (srst_in || !ce_in)
    wr0_ok |=>
      (crossover_algorithm_select_out[0] == $past(port_wdata[BIT_XOVER_ALGO])) &&
      (forced_wiring_select_out[0] == $past(port_wdata[BIT_FORCED_WIRING])) &&
      (auto_crossover_disable_out[0] == $past(port_wdata[BIT_AUTO_XOVER_DIS]));
  endproperty
  a_crossover_write: assert property (p_crossover_write)
    else $error("crossover control bits not taken");

  property p_disable_bits_write;
    @(posedge ref_clk_in) disable iff (srst_in || !ce_in)
    wr0_ok |=> (far_end_fault_disable_out[0] == $past(port_wdata[BIT_FEF_DISABLE])) &&
               (tx_disable_out[0] == $past(port_wdata[BIT_TX_DISABLE])) &&
               (indicator_disable_out[0] == $past(port_wdata[BIT_INDICATOR_DIS]));
  endproperty
  a_disable_bits_write: assert property (p_disable_bits_write)
    else $error("fault, transmit or indicator disable bit not taken");

  property p_restart_pulse;
    @(posedge ref_clk_in) disable iff (srst_in || !ce_in)
    (wr0_ok && port_wdata[BIT_AUTONEG_RESTART]) |=>
      autoneg_restart_out[0] ##1 !autoneg_restart_out[0];
  endproperty
  a_restart_pulse: assert property (p_restart_pulse)
    else $error("restart pulse wrong");

  property p_reserved_zero;
    @(posedge ref_clk_in) disable iff (srst_in)
    (ctrl_vec[0][7:6] == 2'b00) && (ctrl_vec[0][BIT_AUTONEG_RESTART] == 1'b0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved control bits not zero");

  property p_busy_drops_write;
    @(posedge ref_clk_in) disable iff (srst_in || !ce_in)
    (soft_busy[0] && port_wr_en[0] && $stable(soft_busy[0])) |=>
      $stable(ctrl_vec[0][14:0]);
  endproperty
  a_busy_drops_write: assert property (p_busy_drops_write)
    else $error("write taken during soft reset");

  c_mgmt_write: cover property (@(posedge ref_clk_in) mgmt_wr_ctrl);
  c_spi_read:   cover property (@(posedge ref_clk_in) spi_take && !spi_wr_in);
  c_soft_reset: cover property (@(posedge ref_clk_in) $rose(soft_busy[0]));
  c_both_req:   cover property (@(posedge ref_clk_in) mgmt_take && spi_req_in);

endmodule : pbcr_bank

// >>> pbcr_station.sv
/*
  management station model: one request at a time on a req/ack port.
  assumes the bank answers within a few cycles on the same clock.
*/
module pbcr_station (
  input  wire logic        clk_in,
  input  wire logic        ack_in,
  input  wire logic        err_in,
  input  wire logic [15:0] rdata_in,
  output logic             req_out,
  output logic             wr_out,
  output logic      [9:0]  addr_out,
  output logic      [15:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_out = 1'b0;
    wr_out = 1'b0;
    addr_out = 10'h000;
    wdata_out = 16'h0000;
  end
  // ==========================================================================
  // one transfer, driven on falling edges
  // ==========================================================================
  task automatic xfer(input logic wr, input logic [9:0] addr, input logic [15:0] wd,
                      output logic err, output logic [15:0] rd);
    int n;
    err = 1'bx;
    rd = 16'hXXXX;
    @(negedge clk_in);
    req_out = 1'b1;
    wr_out = wr;
    addr_out = addr;
    wdata_out = wd;
    for (n = 0; n < 40 && ack_in !== 1'b1; n++) @(negedge clk_in);
    if (ack_in === 1'b1) begin
      err = err_in;
      rd = rdata_in;
    end
    // held past the ack edge; released lines carry the inverse, not old values
    @(negedge clk_in);
    req_out = 1'b0;
    wr_out = ~wr;
    addr_out = ~addr;
    wdata_out = ~wd;
  endtask : xfer
endmodule : pbcr_station

// >>> tb.sv
/*
  self-checking bench for the basic control bank: table of accesses on both
  request ports, then restart, contention, soft reset, clock-enable and reset cases.
  assumes the bank answers each request one cycle after it is taken.
*/
module tb
  import pbcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic spi; logic wr; logic [9:0] a; logic [15:0] wd; logic err; logic [15:0] rd;
  } pbcr_row_s;
  localparam int NR = 16;
  localparam int FB [12] = '{14, 13, 12, 11, 10, 8, 5, 4, 3, 2, 1, 0};
  localparam pbcr_row_s ROWS [NR] = '{
    '{1'b0, 1'b0, 10'h020, 16'h0000, 1'b0, 16'h3120}, '{1'b0, 1'b1, 10'h020, 16'h7FFF, 1'b0, 16'h0000},
    '{1'b0, 1'b0, 10'h020, 16'h0000, 1'b0, 16'h7D3F}, '{1'b1, 1'b0, 10'h020, 16'h0000, 1'b0, 16'h3120},
    '{1'b1, 1'b1, 10'h040, 16'h0000, 1'b0, 16'h0000}, '{1'b0, 1'b0, 10'h060, 16'h0000, 1'b0, 16'h0000},
    '{1'b0, 1'b0, 10'h000, 16'h0000, 1'b1, 16'h0000}, '{1'b0, 1'b0, 10'h080, 16'h0000, 1'b1, 16'h0000},
    '{1'b0, 1'b0, 10'h045, 16'h0000, 1'b0, 16'h0000}, '{1'b0, 1'b0, 10'h046, 16'h0000, 1'b1, 16'h0000},
    '{1'b0, 1'b0, 10'h05D, 16'h0000, 1'b0, 16'h0000}, '{1'b0, 1'b0, 10'h05F, 16'h0000, 1'b0, 16'h0000},
    '{1'b0, 1'b0, 10'h05E, 16'h0000, 1'b1, 16'h0000}, '{1'b1, 1'b0, 10'h060, 16'h0000, 1'b1, 16'h0000},
    '{1'b0, 1'b1, 10'h043, 16'hFFFF, 1'b0, 16'h0000}, '{1'b0, 1'b0, 10'h040, 16'h0000, 1'b0, 16'h3120}};
  logic        ref_clk, srst, ce, m_req, m_wr, m_ack, m_err, s_req, s_wr, s_ack, s_err, e, e2;
  logic [9:0]  m_a, s_a;
  logic [15:0] m_wd, m_rd, s_wd, s_rd, d, d2;
  logic [2:0]  sr, lb, sp, an, pd, iso, rs, dup, xa, fw, axd, fef, txd, led;
  logic [35:0] lv;
  int          n_mismatch, samples_checked, cyc, rs_cnt, sr_cnt, i;
  assign lv = {lb, sp, an, pd, iso, dup, xa, fw, axd, fef, txd, led};
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  pbcr_bank dut_u (
    .ref_clk_in(ref_clk), .srst_in(srst), .ce_in(ce), .mgmt_req_in(m_req), .mgmt_wr_in(m_wr),
    .mgmt_phy_addr_in(m_a[9:5]), .mgmt_reg_addr_in(m_a[4:0]), .mgmt_wdata_in(m_wd),
    .mgmt_ack_out(m_ack), .mgmt_err_out(m_err), .mgmt_rdata_out(m_rd), .spi_req_in(s_req),
    .spi_wr_in(s_wr), .spi_addr_in(s_a[7:0]), .spi_wdata_in(s_wd), .spi_ack_out(s_ack),
    .spi_err_out(s_err), .spi_rdata_out(s_rd), .phy_soft_reset_out(sr), .mac_loopback_out(lb),
    .speed_100_out(sp), .autoneg_enable_out(an), .power_down_out(pd), .line_isolate_out(iso),
    .autoneg_restart_out(rs), .duplex_full_out(dup), .crossover_algorithm_select_out(xa),
    .forced_wiring_select_out(fw), .auto_crossover_disable_out(axd),
    .far_end_fault_disable_out(fef), .tx_disable_out(txd), .indicator_disable_out(led));
  pbcr_station m_u (.clk_in(ref_clk), .ack_in(m_ack), .err_in(m_err), .rdata_in(m_rd),
    .req_out(m_req), .wr_out(m_wr), .addr_out(m_a), .wdata_out(m_wd));
  pbcr_station s_u (.clk_in(ref_clk), .ack_in(s_ack), .err_in(s_err), .rdata_in(s_rd),
    .req_out(s_req), .wr_out(s_wr), .addr_out(s_a), .wdata_out(s_wd));
  // ==========================================================================
  // checking and access helpers
  // ==========================================================================
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic acc(input logic spi, input logic wr, input logic [9:0] a,
                     input logic [15:0] wd);
    if (spi) s_u.xfer(wr, a, wd, e, d);
    else m_u.xfer(wr, a, wd, e, d);
  endtask : acc
  // per-port control levels compared with the register images of ports 0..2
  task automatic lvl(input logic [15:0] p0, input logic [15:0] p1, input logic [15:0] p2);
    logic [35:0] x;
    for (int k = 0; k < 12; k++) x[35-3*k -: 3] = {p2[FB[k]], p1[FB[k]], p0[FB[k]]};
    chk(lv, x);
  endtask : lvl
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  always @(negedge ref_clk) begin
    if (rs !== 3'b000) rs_cnt++;
    if (sr[0] === 1'b1) sr_cnt++;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      summarize();
    end
  end
  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    repeat (20) @(negedge ref_clk);
    srst = 1'b0;
    @(negedge ref_clk);
    lvl(CTRL_RESET_VAL, CTRL_RESET_VAL, CTRL_RESET_VAL);
    chk({sr, rs}, 36'h0);
    for (i = 0; i < NR; i++) begin
      acc(ROWS[i].spi, ROWS[i].wr, ROWS[i].a, ROWS[i].wd);
      chk({e, d}, {ROWS[i].err, ROWS[i].rd});
    end
    lvl(16'h7D3F, CTRL_RESET_VAL, 16'h0000);
    acc(1'b0, 1'b1, 10'h040, 16'h3320);
    acc(1'b0, 1'b0, 10'h040, 16'h0000);
    chk({rs_cnt, d}, {32'd2, 16'h3120});
    // both ports at once: management goes first, host request waits its turn
    fork
      m_u.xfer(1'b0, 10'h040, 16'h0000, e, d);
      s_u.xfer(1'b0, 10'h020, 16'h0000, e2, d2);
    join
    chk({e, d, e2, d2}, {1'b0, 16'h3120, 1'b0, 16'h3120});
    acc(1'b1, 1'b1, 10'h000, 16'h8000);
    chk(sr, 3'b001);
    acc(1'b0, 1'b0, 10'h020, 16'h0000);
    chk(d, 16'hB120);
    acc(1'b0, 1'b1, 10'h020, 16'h0000);
    // poll until the self-clearing bit drops before touching the port again
    i = 0;
    do begin
      acc(1'b0, 1'b0, 10'h020, 16'h0000);
      i++;
    end while (i < 30 && d[15] !== 1'b0);
    chk({sr_cnt, d}, {32'(SOFT_RST_CYCLES), 16'h3120});
    lvl(CTRL_RESET_VAL, CTRL_RESET_VAL, 16'h0000);
    // clock enable low freezes everything: a held request waits, then lands
    ce = 1'b0;
    fork
      acc(1'b0, 1'b1, 10'h060, 16'h0800);
      begin
        repeat (4) @(negedge ref_clk);
        chk({m_ack, pd}, 4'h0);
        ce = 1'b1;
      end
    join
    lvl(CTRL_RESET_VAL, CTRL_RESET_VAL, 16'h0800);
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    acc(1'b1, 1'b0, 10'h040, 16'h0000);
    chk({e, d}, {1'b0, 16'h3120});
    lvl(CTRL_RESET_VAL, CTRL_RESET_VAL, CTRL_RESET_VAL);
    summarize();
  end
endmodule : tb
